//--- hdl/gpcg_pkg.sv
// Constants shared by the pin control group
//
// What this block does
// - Bit 0 of every pin control register makes the pin an input when one, an output when zero; under disable write control pin 4.3 is always an input.
// - Bit 1 of every pin control register inverts the pin value between pad and core when one; pin 4.3 input is not inverted under disable write control.
// - Bit 7 of every pin control register selects an open-drain driver when one, push-pull when zero.
// - Bit 2 of the pin 3.7 register routes the gate-A20 mask to the pin; bits 6 to 3 are reserved.
// - Bit 2 of the pin 4.0 register connects drive density select 0 to the pin.
// - Bits 3:2 of the pin 4.1 register pick general purpose, drive density 1, edge interrupt 2 or reserved.
// - Bit 2 of the pin 4.2 register selects the power-management event output.
// - The power event output on pin 4.2 is active low when it is a non-inverted output, either driver.
// - Bits 3:2 of the pin 4.3 register pick general purpose, disable write control, reserved or edge interrupt 3.
// - Once pin 4.3 bits 3:2 hold 01, software writes cannot change those two bits.
// - Once they hold 01, pin 4.3 bits 3:2 are cleared only by standby-power reset, or by main-power or hard reset on an edge with clock enable high.
// - Under disable write control a high pin 4.3 makes the disable register read-only, low makes it writable.
// - Bits 3:2 of the pin 5.0 register at 01 connect the port 2 ring indicator input to the pin.
// - Bits 3:2 of the pin 5.1 register at 01 connect the port 2 carrier detect input to the pin.
package gpcg_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_PINS = 7;
    localparam int NUM_EDGE = 2;

    // ****************************************
    // Pin slots
    // ****************************************
    localparam int P37 = 0;
    localparam int P40 = 1;
    localparam int P41 = 2;
    localparam int P42 = 3;
    localparam int P43 = 4;
    localparam int P50 = 5;
    localparam int P51 = 6;

    // ****************************************
    // Control register indexes, byte address is four times
    // ****************************************
    localparam logic [7:0] IDX_PIN_3_7 = 8'h3A;
    localparam logic [7:0] IDX_PIN_4_0 = 8'h3B;
    localparam logic [7:0] IDX_PIN_4_1 = 8'h3C;
    localparam logic [7:0] IDX_PIN_4_2 = 8'h3D;
    localparam logic [7:0] IDX_PIN_4_3 = 8'h3E;
    localparam logic [7:0] IDX_PIN_5_0 = 8'h3F;
    localparam logic [7:0] IDX_PIN_5_1 = 8'h40;
    localparam logic [7:0] CTRL_IDX [NUM_PINS] = '{IDX_PIN_3_7, IDX_PIN_4_0, IDX_PIN_4_1,
        IDX_PIN_4_2, IDX_PIN_4_3, IDX_PIN_5_0, IDX_PIN_5_1};

    // ****************************************
    // Added registers
    // ****************************************
    localparam logic [11:0] ADDR_DATA_OUT = 12'h200;
    localparam logic [11:0] ADDR_DATA_IN = 12'h204;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h208;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h20C;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int BIT_DIR = 0;
    localparam int BIT_POL = 1;
    localparam int BIT_ALT = 2;
    localparam int BIT_OD = 7;
    localparam int FN_LO = 2;
    localparam int FN_HI = 3;
    localparam logic [7:0] CTRL_RESET = 8'h01;
    localparam logic [7:0] WMASK_ONE = 8'h87;
    localparam logic [7:0] WMASK_TWO = 8'h8F;
    localparam logic [7:0] CTRL_WMASK [NUM_PINS] = '{WMASK_ONE, WMASK_ONE, WMASK_TWO,
        WMASK_ONE, WMASK_TWO, WMASK_TWO, WMASK_TWO};
    localparam logic [NUM_PINS-1:0] DATA_OUT_RESET = 7'h00;
    localparam logic [NUM_EDGE-1:0] IRQ_MASK_RESET = 2'h0;

    // ****************************************
    // Function codes of two-bit select fields
    // ****************************************
    localparam logic [1:0] FN_GPIO = 2'h0;
    localparam logic [1:0] FN_ALT1 = 2'h1;
    localparam logic [1:0] FN_ALT2 = 2'h2;
    localparam logic [1:0] FN_ALT3 = 2'h3;

endpackage : gpcg_pkg

//--- hdl/gpcg_pin_cell.sv
// One pad cell: direction, polarity and driver type
module gpcg_pin_cell
    import gpcg_pkg::*;
(
    input  wire logic [7:0] ctrl_i,    // Control register
    input  wire logic       data_i,    // Output data
    input  wire logic       alt_en_i,  // Alternate output owns pin
    input  wire logic       alt_val_i, // Alternate output value
    input  wire logic       force_in_i, // Force input mode
    input  wire logic       pad_in_i,  // Pad level
    output logic            pad_out_o, // Pad drive value
    output logic            pad_oe_o,  // Pad drive enable
    output logic            in_val_o   // Core side input value
);

    logic out_val;
    logic drive;

    assign out_val = (alt_en_i ? alt_val_i : data_i) ^ ctrl_i[BIT_POL];
    assign in_val_o = pad_in_i ^ (ctrl_i[BIT_POL] & ~force_in_i);

    assign drive = ~force_in_i & ~ctrl_i[BIT_DIR];

    assign pad_oe_o = drive & (~ctrl_i[BIT_OD] | ~out_val);
    assign pad_out_o = out_val & ~ctrl_i[BIT_OD];

endmodule : gpcg_pin_cell

//--- hdl/gpcg_top.sv
// Pin control group with APB register access
//
// Decided for this implementation: register access over APB.
module gpcg_top
    import gpcg_pkg::*;
(
    input  wire logic                ref_clk_i,        // 100 MHz clock
    input  wire logic                rstn_i,           // Standby-power reset, low
    input  wire logic                main_power_rst_n_i, // Main-power reset, low
    input  wire logic                hard_rst_n_i,     // Hard reset, low
    input  wire logic                ce_i,             // Clock enable
    input  wire logic                psel_i,           // APB select
    input  wire logic                penable_i,        // APB enable
    input  wire logic                pwrite_i,         // APB write
    input  wire logic [11:0]         paddr_i,          // APB byte address
    input  wire logic [31:0]         pwdata_i,         // APB write data
    input  wire logic [3:0]          pstrb_i,          // APB byte strobes
    output logic [31:0]              prdata_o,         // APB read data
    output logic                     pready_o,         // APB ready
    output logic                     pslverr_o,        // APB error
    input  wire logic [NUM_PINS-1:0] pad_in_i,         // Pad levels
    output logic [NUM_PINS-1:0]      pad_out_o,        // Pad drive values
    output logic [NUM_PINS-1:0]      pad_oe_o,         // Pad drive enables
    input  wire logic                gate_a20_mask_i,  // Gate-A20 mask source
    input  wire logic                drive_density_sel0_i, // Density select 0 source
    input  wire logic                drive_density_sel1_i, // Density select 1 source
    input  wire logic                power_event_req_i, // Power event request, high
    output logic                     ring_indicator_port2_n_o, // Port 2 ring, low
    output logic                     carrier_detect_port2_n_o, // Port 2 carrier, low
    output logic                     disable_reg_read_only_o, // Disable register locked
    output logic                     irq_o             // Interrupt, high
);

    // ****************************************
    // State
    // ****************************************
    logic [7:0] ctrl_q [NUM_PINS];
    logic [NUM_PINS-1:0] data_out_q;
    logic [NUM_EDGE-1:0] irq_status_q;
    logic [NUM_EDGE-1:0] irq_status_d;
    logic [NUM_EDGE-1:0] irq_mask_q;
    logic [NUM_EDGE-1:0] edge_prev_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [NUM_PINS-1:0] pad_out_q;
    logic [NUM_PINS-1:0] pad_oe_q;
    logic ring_q;
    logic carrier_q;
    logic ro_q;
    logic irq_q;

    // ****************************************
    // Bus decode
    // ****************************************
    logic setup;
    logic access;
    logic wr_en;
    logic [NUM_PINS-1:0] ctrl_hit;
    logic hit;
    logic [31:0] rd_data;

    assign setup = psel_i & ~penable_i & ~pready_q;
    assign access = psel_i & penable_i & pready_q;
    assign wr_en = access & pwrite_i & pstrb_i[0];

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++)
        begin : g_hit
            assign ctrl_hit[g] = (paddr_i == {2'h0, CTRL_IDX[g], 2'h0});
        end
    endgenerate

    // ****************************************
    // Pin side values
    // ****************************************
    logic [NUM_PINS-1:0] alt_en;
    logic [NUM_PINS-1:0] alt_val;
    logic [NUM_PINS-1:0] force_in;
    logic [NUM_PINS-1:0] in_val;
    logic [NUM_PINS-1:0] cell_out;
    logic [NUM_PINS-1:0] cell_oe;
    logic [1:0] fn41;
    logic [1:0] fn43;
    logic [1:0] fn50;
    logic [1:0] fn51;
    logic [NUM_EDGE-1:0] edge_en;
    logic [NUM_EDGE-1:0] edge_val;
    logic [NUM_EDGE-1:0] edge_evt;

    assign fn41 = ctrl_q[P41][FN_HI:FN_LO];
    assign fn43 = ctrl_q[P43][FN_HI:FN_LO];
    assign fn50 = ctrl_q[P50][FN_HI:FN_LO];
    assign fn51 = ctrl_q[P51][FN_HI:FN_LO];

    always_comb
    begin
        alt_en = '0;
        alt_val = '0;
        force_in = '0;
        alt_en[P37] = ctrl_q[P37][BIT_ALT];
        alt_val[P37] = gate_a20_mask_i;
        // density select 0 on pin 4.0
        alt_en[P40] = ctrl_q[P40][BIT_ALT];
        alt_val[P40] = drive_density_sel0_i;
        // density select 1 on pin 4.1
        alt_en[P41] = (fn41 == FN_ALT1);
        alt_val[P41] = drive_density_sel1_i;
        alt_en[P42] = ctrl_q[P42][BIT_ALT];
        alt_val[P42] = ~power_event_req_i;
        force_in[P43] = (fn43 == FN_ALT1);
    end

    generate
        for (g = 0; g < NUM_PINS; g++)
        begin : g_pin
            gpcg_pin_cell u_cell (
                .ctrl_i(ctrl_q[g]),
                .data_i(data_out_q[g]),
                .alt_en_i(alt_en[g]),
                .alt_val_i(alt_val[g]),
                .force_in_i(force_in[g]),
                .pad_in_i(pad_in_i[g]),
                .pad_out_o(cell_out[g]),
                .pad_oe_o(cell_oe[g]),
                .in_val_o(in_val[g])
            );
        end
    endgenerate

    // ****************************************
    // Edge triggered inputs
    // ****************************************
    // either edge input 2 on pin 4.1
    assign edge_en[0] = (fn41 == FN_ALT2);
    assign edge_val[0] = in_val[P41];
    // either edge input 3 on pin 4.3
    assign edge_en[1] = (fn43 == FN_ALT3);
    assign edge_val[1] = in_val[P43];
    assign edge_evt = edge_en & (edge_val ^ edge_prev_q);

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            edge_prev_q <= '0;
        end
        else if (ce_i)
        begin
            edge_prev_q <= edge_val;
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    generate
        for (g = 0; g < NUM_PINS; g++)
        begin : g_ctrl
            logic [7:0] wval;
            assign wval = pwdata_i[7:0] & CTRL_WMASK[g];

            always_ff @(posedge ref_clk_i)
            begin
                if (!rstn_i)
                begin
                    ctrl_q[g] <= CTRL_RESET;
                end
                else if (ce_i)
                begin
                    if (g == P43)
                    begin
                        if (!main_power_rst_n_i || !hard_rst_n_i)
                        begin
                            ctrl_q[g][FN_HI:FN_LO] <= FN_GPIO;
                        end
                        else if (wr_en && ctrl_hit[g])
                        begin
                            if (ctrl_q[g][FN_HI:FN_LO] == FN_ALT1)
                            begin
                                ctrl_q[g] <= {wval[7:4], FN_ALT1, wval[1:0]};
                            end
                            else
                            begin
                                ctrl_q[g] <= wval;
                            end
                        end
                    end
                    else if (wr_en && ctrl_hit[g])
                    begin
                        ctrl_q[g] <= wval;
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // Data, mask and status registers
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            data_out_q <= DATA_OUT_RESET;
        end
        else if (ce_i && wr_en && paddr_i == ADDR_DATA_OUT)
        begin
            data_out_q <= pwdata_i[NUM_PINS-1:0];
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            irq_mask_q <= IRQ_MASK_RESET;
        end
        else if (ce_i && wr_en && paddr_i == ADDR_IRQ_MASK)
        begin
            irq_mask_q <= pwdata_i[NUM_EDGE-1:0];
        end
    end

    // Set wins over write-one clear
    always_comb
    begin
        irq_status_d = irq_status_q;
        if (wr_en && paddr_i == ADDR_IRQ_STATUS)
        begin
            irq_status_d = irq_status_q & ~pwdata_i[NUM_EDGE-1:0];
        end
        irq_status_d = irq_status_d | edge_evt;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            irq_status_q <= '0;
            irq_q <= 1'b0;
        end
        else if (ce_i)
        begin
            irq_status_q <= irq_status_d;
            irq_q <= |(irq_status_d & irq_mask_q);
        end
    end

    // ****************************************
    // Read mux and APB answer
    // ****************************************
    always_comb
    begin
        rd_data = '0;
        hit = 1'b0;
        for (int k = 0; k < NUM_PINS; k++)
        begin
            if (ctrl_hit[k])
            begin
                rd_data = {24'h00_0000, ctrl_q[k]};
                hit = 1'b1;
            end
        end
        unique case (paddr_i)
            ADDR_DATA_OUT:
            begin
                rd_data[NUM_PINS-1:0] = data_out_q;
                hit = 1'b1;
            end
            ADDR_DATA_IN:
            begin
                rd_data[NUM_PINS-1:0] = in_val;
                hit = 1'b1;
            end
            ADDR_IRQ_STATUS:
            begin
                rd_data[NUM_EDGE-1:0] = irq_status_q;
                hit = 1'b1;
            end
            ADDR_IRQ_MASK:
            begin
                rd_data[NUM_EDGE-1:0] = irq_mask_q;
                hit = 1'b1;
            end
            default:
            begin
            end
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            pready_q <= setup;
            pslverr_q <= setup & ~hit;
            if (setup && !pwrite_i)
            begin
                prdata_q <= rd_data;
            end
        end
    end

    // ****************************************
    // Registered pin and function outputs
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            pad_out_q <= '0;
            pad_oe_q <= '0;
            ring_q <= 1'b1;
            carrier_q <= 1'b1;
            ro_q <= 1'b0;
        end
        else if (ce_i)
        begin
            pad_out_q <= cell_out;
            pad_oe_q <= cell_oe;
            ring_q <= (fn50 == FN_ALT1) ? in_val[P50] : 1'b1;
            carrier_q <= (fn51 == FN_ALT1) ? in_val[P51] : 1'b1;
            ro_q <= (fn43 == FN_ALT1) & pad_in_i[P43];
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign pad_out_o = pad_out_q;
    assign pad_oe_o = pad_oe_q;
    assign ring_indicator_port2_n_o = ring_q;
    assign carrier_detect_port2_n_o = carrier_q;
    assign disable_reg_read_only_o = ro_q;
    assign irq_o = irq_q;

endmodule : gpcg_top

//--- tb/gpcg_board.sv
// Board model: pad wires with the levels the board puts on them
module gpcg_board
    import gpcg_pkg::*;
(
    input  wire logic [NUM_PINS-1:0] pad_out_i, // Design drive value
    input  wire logic [NUM_PINS-1:0] pad_oe_i,  // Design drive enable
    input  wire logic [NUM_PINS-1:0] ext_i,     // Board level or pull-up when released
    output logic [NUM_PINS-1:0] pad_o           // Resolved pad level
);
    timeunit 1ns;
    timeprecision 1ns;

    always_comb
    begin
        for (int i = 0; i < NUM_PINS; i++)
        begin
            pad_o[i] = pad_oe_i[i] ? pad_out_i[i] : ext_i[i];
        end
    end
endmodule : gpcg_board

//--- tb/gpcg_checker.sv
// Port assertions for the pin control group
module gpcg_checker
    import gpcg_pkg::*;
(
    input wire logic ref_clk_i,                // Clock
    input wire logic rstn_i,                   // Reset, low
    input wire logic main_power_rst_n_i,       // Main-power reset, low
    input wire logic hard_rst_n_i,             // Hard reset, low
    input wire logic ce_i,                     // Clock enable
    input wire logic psel_i,                   // APB select
    input wire logic penable_i,                // APB enable
    input wire logic pwrite_i,                 // APB write
    input wire logic pready_o,                 // APB ready
    input wire logic pslverr_o,                // APB error
    input wire logic [NUM_PINS-1:0] pad_in_i,  // Pad levels
    input wire logic [NUM_PINS-1:0] pad_oe_o,  // Pad enables
    input wire logic disable_reg_read_only_o,  // Lock output
    input wire logic irq_o                     // Interrupt
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    AST_RESET_IDLE: assert property (
        $rose(rstn_i) |-> pad_oe_o == '0 && !irq_o ##1 pad_oe_o == '0)
        else $error("pads driven after reset");
    AST_READY_NEXT: assert property (
        psel_i && !penable_i && !pready_o && ce_i |=> pready_o)
        else $error("no ready after setup");
    AST_READY_ONE: assert property (
        pready_o && ce_i |=> !pready_o)
        else $error("ready held too long");
    AST_ERR_WITH_READY: assert property (
        pslverr_o |-> pready_o)
        else $error("error without ready");
    AST_RO_PIN: assert property (
        disable_reg_read_only_o && $past(ce_i) |-> $past(pad_in_i[4]))
        else $error("lock output without high pin");
    AST_RO_INPUT: assert property (
        disable_reg_read_only_o |-> !pad_oe_o[4])
        else $error("lock pin driven");
    AST_RO_RELEASE: assert property (
        $fell(disable_reg_read_only_o) |-> !$past(pad_in_i[4])
        || !$past(main_power_rst_n_i, 2) || !$past(hard_rst_n_i, 2))
        else $error("lock released without cause");
    AST_IRQ_CAUSE: assert property (
        $rose(irq_o) |-> $past(pad_in_i[2]) != $past(pad_in_i[2], 2)
        || $past(pad_in_i[4]) != $past(pad_in_i[4], 2)
        || $past(psel_i && pwrite_i) || $past(psel_i && pwrite_i, 2))
        else $error("interrupt without cause");
endmodule : gpcg_checker

bind gpcg_top gpcg_checker i_gpcg_checker (.ref_clk_i, .rstn_i, .main_power_rst_n_i,
    .hard_rst_n_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .pready_o, .pslverr_o, .pad_in_i,
    .pad_oe_o, .disable_reg_read_only_o, .irq_o);

//--- tb/test_gpcg_top.sv
// Self-checking bench for the pin control group
module test_gpcg_top
    import gpcg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic ce, rstn, mrst_n, hrst_n, psel, penable, pwrite, a20, dd0, dd1, req;
    logic pready, pslverr, ring_n, dcd_n, ro, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [NUM_PINS-1:0] pad_in, pad_out, pad_oe, ext;
    logic [7:0] ctrl_m [NUM_PINS];
    logic [6:0] dout_m;
    logic [1:0] st_m, mask_m;
    logic [32:0] rd_v;
    int miscompares, checked;

    gpcg_top i_gpcg_top (.ref_clk_i(clk), .rstn_i(rstn), .main_power_rst_n_i(mrst_n),
        .hard_rst_n_i(hrst_n), .ce_i(ce), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pad_in_i(pad_in),
        .pad_out_o(pad_out), .pad_oe_o(pad_oe), .gate_a20_mask_i(a20),
        .drive_density_sel0_i(dd0), .drive_density_sel1_i(dd1), .power_event_req_i(req),
        .ring_indicator_port2_n_o(ring_n), .carrier_detect_port2_n_o(dcd_n),
        .disable_reg_read_only_o(ro), .irq_o(irq));
    gpcg_board i_gpcg_board (.pad_out_i(pad_out), .pad_oe_i(pad_oe), .ext_i(ext),
        .pad_o(pad_in));

    initial
    begin
        forever #5 clk = ~clk;
    end

    // ****************************************
    // Tasks and model
    // ****************************************
    task automatic finish_test();
        if (miscompares == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    task automatic cmp_reg(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_reg

    task automatic cmp_pins(input logic [17:0] got, input logic [17:0] exp);
        cmp_reg({15'h0000, got}, {15'h0000, exp});
    endtask : cmp_pins

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        input logic [3:0] st);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd_v = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    function automatic logic [11:0] ctrl_addr(int i);
        return {2'b00, CTRL_IDX[i], 2'b00};
    endfunction : ctrl_addr

    task automatic wr_ctrl(int i, logic [7:0] v, logic [3:0] st);
        logic [7:0] nv;
        nv = v & CTRL_WMASK[i];
        if (i == P43 && ctrl_m[P43][3:2] == 2'b01)
            nv[3:2] = 2'b01;
        if (st[0])
            ctrl_m[i] = nv;
        apb(1'b1, ctrl_addr(i), 32'(v), st);
    endtask : wr_ctrl

    function automatic logic [17:0] exp_pins();
        logic [6:0] o, e;
        logic [1:0] fn;
        logic v, ri, dc;
        ri = 1'b1;
        dc = 1'b1;
        for (int i = 0; i < NUM_PINS; i++)
        begin
            fn = CTRL_WMASK[i][3] ? ctrl_m[i][3:2] : {1'b0, ctrl_m[i][2]};
            v = dout_m[i];
            if (i == P37 && fn == 2'b01) v = a20;
            if (i == P40 && fn == 2'b01) v = dd0;
            if (i == P41 && fn == 2'b01) v = dd1;
            if (i == P42 && fn == 2'b01) v = ~req;
            v = v ^ ctrl_m[i][1];
            e[i] = ~ctrl_m[i][0] & ~(i == P43 && fn == 2'b01) & ~(ctrl_m[i][7] & v);
            o[i] = v & ~ctrl_m[i][7];
            if (i == P50 && fn == 2'b01) ri = pad_in[5] ^ ctrl_m[i][1];
            if (i == P51 && fn == 2'b01) dc = pad_in[6] ^ ctrl_m[i][1];
        end
        return {|(st_m & mask_m), ctrl_m[P43][3:2] == 2'b01 && pad_in[4], dc, ri, e, o};
    endfunction : exp_pins

    function automatic logic [6:0] din_exp();
        logic [6:0] d;
        for (int i = 0; i < NUM_PINS; i++)
        begin
            d[i] = pad_in[i] ^ ctrl_m[i][1];
        end
        if (ctrl_m[P43][3:2] == 2'b01)
            d[4] = pad_in[4];
        return d;
    endfunction : din_exp

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        logic [7:0] v;
        logic [17:0] pins_v;
        {rstn, psel, penable, pwrite, a20, dd0, dd1, req} = '0;
        {ce, mrst_n, hrst_n, ext} = '1;
        {paddr, pwdata, pstrb} = '0;
        foreach (ctrl_m[i]) ctrl_m[i] = CTRL_RESET;
        {dout_m, st_m, mask_m} = '0;
        void'($urandom(88));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < NUM_PINS; i++)
        begin
            apb(1'b0, ctrl_addr(i), 32'h0000_0000, 4'hF);
            cmp_reg(rd_v, 33'(ctrl_m[i]));
        end
        for (int it = 0; it < 56; it++)
        begin
            v = 8'($urandom());
            v[3:2] = 2'(3 - it / 7);
            wr_ctrl(it % 7, v, 4'h1);
            dout_m = 7'($urandom());
            apb(1'b1, ADDR_DATA_OUT, 32'(dout_m), 4'h1);
            repeat (2) @(posedge clk);
            pins_v = exp_pins();
            // Clock enable low freezes all outputs
            ce <= 1'b0;
            {ext, a20, dd0, dd1, req} <= 11'($urandom());
            repeat (3) @(posedge clk);
            cmp_pins({irq, ro, dcd_n, ring_n, pad_oe, pad_out}, pins_v);
            ce <= 1'b1;
            repeat (3) @(posedge clk);
            cmp_pins({irq, ro, dcd_n, ring_n, pad_oe, pad_out}, exp_pins());
            apb(1'b0, ctrl_addr(it % 7), 32'h0000_0000, 4'hF);
            cmp_reg(rd_v, 33'(ctrl_m[it % 7]));
            apb(1'b0, ADDR_DATA_IN, 32'h0000_0000, 4'hF);
            cmp_reg(rd_v, 33'(din_exp()));
        end
        wr_ctrl(P37, 8'hFF, 4'h0);
        apb(1'b0, ctrl_addr(P37), 32'h0000_0000, 4'hF);
        cmp_reg(rd_v, 33'(ctrl_m[P37]));
        apb(1'b1, 12'h044, 32'hFFFF_FFFF, 4'hF);
        apb(1'b0, 12'h044, 32'h0000_0000, 4'hF);
        cmp_reg(rd_v, 33'h1_0000_0000);
        for (int k = 0; k < 3; k++)
        begin
            wr_ctrl(P43, 8'h05, 4'h1);
            wr_ctrl(P43, 8'h0B, 4'h1);
            ext <= k ? 7'h00 : 7'h10;
            apb(1'b0, ctrl_addr(P43), 32'h0000_0000, 4'hF);
            cmp_reg(rd_v, 33'(ctrl_m[P43]));
            cmp_pins({irq, ro, dcd_n, ring_n, pad_oe, pad_out}, exp_pins());
            mrst_n <= (k != 0);
            hrst_n <= (k != 1);
            rstn <= (k != 2);
            @(posedge clk);
            {mrst_n, hrst_n, rstn} <= 3'b111;
            @(posedge clk);
            ctrl_m[P43][3:2] = 2'b00;
            if (k == 2)
            begin
                foreach (ctrl_m[i]) ctrl_m[i] = CTRL_RESET;
                dout_m = '0;
            end
            apb(1'b0, ctrl_addr(P43), 32'h0000_0000, 4'hF);
            cmp_reg(rd_v, 33'(ctrl_m[P43]));
        end
        wr_ctrl(P41, 8'h09, 4'h1);
        wr_ctrl(P43, 8'h0D, 4'h1);
        for (int k = 0; k < 4; k++)
        begin
            mask_m = k < 2 ? 2'b11 : 2'b00;
            apb(1'b1, ADDR_IRQ_MASK, 32'(mask_m), 4'h1);
            apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_0003, 4'h1);
            st_m = 2'b00;
            ext <= ext ^ (k[0] ? 7'h10 : 7'h04);
            repeat (3) @(posedge clk);
            st_m[k % 2] = 1'b1;
            cmp_pins({irq, ro, dcd_n, ring_n, pad_oe, pad_out}, exp_pins());
            apb(1'b0, ADDR_IRQ_STATUS, 32'h0000_0000, 4'hF);
            cmp_reg(rd_v, 33'(st_m));
            apb(1'b1, ADDR_IRQ_STATUS, 32'(st_m), 4'h1);
            st_m = 2'b00;
            cmp_pins({irq, ro, dcd_n, ring_n, pad_oe, pad_out}, exp_pins());
        end
        finish_test();
    end

    initial
    begin
        #500000;
        miscompares++;
        finish_test();
    end
endmodule : test_gpcg_top
